/* hw/mrtc_params.svh */
/*
  Constants of the mains-timed clock and calendar block: register indices,
  field positions, reset values and timing figures.
  Assumes a 20 MHz system clock and a word-addressed Avalon-MM slave port.
*/
// How it works
// - All timekeeping counts edges of the mains input.
// - Tenths carry into seconds up to year.
// - Short months end on their true last day.
// - February leap years handled through 2099.
// - Control bit picks 24-hour or 12-hour AM/PM.
// - Counters halt after power-up until a time write.
// - Power-loss flag set at every start-up.
// - Alarm match state readable in the status register.
// - Alarm compares seconds through month and weekday.
// - Field joins match only when its MSB set.
// - Mode bit zero single-event, one pulsed.
// - Single match pulls interrupt low, sets flag.
// - Writing zero clears an alarm flag.
// - Auto-clear bit lets a status read clear flags.
// - Pulsed mode repeats on every match unattended.
// - Recurrence follows the enabled alarm fields.
// - Pulsed match drives interrupt low 250 ms.
// - Interrupt is open-drain and active low.
// - All time counts are held in BCD.
// - Time writes only while write-enable bit set.
// - Any time write zeroes the tenths count.
`ifndef MRTC_PARAMS_SVH
`define MRTC_PARAMS_SVH

`define MRTC_CLK_HZ 20000000
`define MRTC_PULSE_MS 250
`define MRTC_PCNT_W 23
`define MRTC_DIV50 3'h5
`define MRTC_DIV60 3'h6

`define MRTC_A_SC 6'h00
`define MRTC_A_MN 6'h01
`define MRTC_A_HR 6'h02
`define MRTC_A_DT 6'h03
`define MRTC_A_MO 6'h04
`define MRTC_A_YR 6'h05
`define MRTC_A_DW 6'h06
`define MRTC_A_SS 6'h07
`define MRTC_A_STAT 6'h08
`define MRTC_A_INT 6'h0c
`define MRTC_A_AC 6'h13
`define MRTC_A_AL0 6'h1d
`define MRTC_AL_FIELDS 6

`define MRTC_B_PLF 0
`define MRTC_B_ALMA 4
`define MRTC_B_ACLR 7
`define MRTC_B_WEN 6
`define MRTC_B_PMODE 5
`define MRTC_B_ALEA 0
`define MRTC_B_AC60 7
`define MRTC_B_MIL 7
`define MRTC_B_PM 5
`define MRTC_B_EN 7

`define MRTC_RST_ONE 8'h01
`define MRTC_MAX_SS 8'h09
`define MRTC_MAX_SEC 8'h59
`define MRTC_MAX_HR24 6'h23
`define MRTC_HR12_TOP 5'h12
`define MRTC_HR12_LAST 5'h11
`define MRTC_MAX_DW 8'h06
`define MRTC_MAX_MO 8'h12
`define MRTC_MAX_YR 8'h99

`endif

/* hw/mrtc_pkg.sv */
/*
  Types shared by the clock block: bus carriers, time record and state.
  Assumes mrtc_params.svh is on the include path.
*/
`include "mrtc_params.svh"
package mrtc_pkg;
  typedef struct packed {
    logic [5:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } mrtc_avs_req_s;
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } mrtc_avs_rsp_s;
  typedef struct packed {
    logic [7:0] ss, dw, yr, mo, dt, hr, mn, sc;
  } mrtc_time_s;
  // Alarm fields: 0 seconds, 1 minutes, 2 hours, 3 date, 4 month, 5 weekday.
  typedef logic [`MRTC_AL_FIELDS-1:0][7:0] mrtc_alarm_t;
  typedef struct packed {
    logic ack;
    logic sync1, sync2, prev;
    logic [2:0] div;
    logic run, plf, aclr, wen, pmode, ac60;
    logic [1:0] flag, ale, match_prev;
    mrtc_time_s tm;
    mrtc_alarm_t [1:0] al;
    logic [`MRTC_PCNT_W-1:0] pcnt;
    logic irq_oe;
    logic [31:0] rdata;
  } mrtc_state_s;
endpackage

/* hw/mrtc_top.sv */
/*
  Mains-timed clock/calendar with two alarms behind an Avalon-MM slave.
  Assumes the mains input is a squared-up asynchronous level, the interrupt
  pin has an external pull-up, and the bus master holds its request while
  waitrequest is high.
*/
// Chosen here: the Avalon-MM interface to the registers and the address map.
`include "mrtc_params.svh"
module mrtc_top #(
  parameter logic [`MRTC_PCNT_W-1:0] PULSE_CYCLES =
    `MRTC_PCNT_W'(`MRTC_CLK_HZ / 1000 * `MRTC_PULSE_MS)
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Register bus
  input wire mrtc_pkg::mrtc_avs_req_s i_avs,
  output mrtc_pkg::mrtc_avs_rsp_s o_avs,
  // Mains timing input
  input wire logic i_mains,
  // Open-drain interrupt, low when driven
  output logic o_irq_out,
  output logic o_irq_oe
);
  import mrtc_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  function automatic logic is_leap(input logic [7:0] y);
    if (y[4]) begin
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
  endfunction

  function automatic logic [7:0] days_in(input logic [7:0] m, input logic lp);
    unique case (m)
      8'h02: days_in = lp ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: days_in = 8'h30;
      default: days_in = 8'h31;
    endcase
  endfunction

  mrtc_state_s s_reg;
  mrtc_state_s s_next;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic req;
  logic acc;
  logic wr;
  logic wr_time;
  logic rd_stat;
  logic [7:0] wd;
  assign req = i_avs.read | i_avs.write;
  assign acc = req & s_reg.ack;
  assign wr = acc & i_avs.write & i_avs.byteenable[0];
  // Writes to the time section are dropped unless write enable is set.
  assign wr_time = wr & s_reg.wen & (i_avs.address <= `MRTC_A_SS);
  assign rd_stat = acc & i_avs.read & (i_avs.address == `MRTC_A_STAT);
  assign wd = i_avs.writedata[7:0];
  assign o_avs.waitrequest = req & ~s_reg.ack;
  assign o_avs.readdata = s_reg.rdata;
  assign o_irq_out = 1'b0;
  assign o_irq_oe = s_reg.irq_oe;

  // ----------------------------------------------------------------------
  // Alarm comparators
  // ----------------------------------------------------------------------
  logic [`MRTC_AL_FIELDS-1:0][7:0] tv;
  logic [1:0] match;
  logic [1:0] ev;
  assign tv = {s_reg.tm.dw, s_reg.tm.mo, s_reg.tm.dt, s_reg.tm.hr, s_reg.tm.mn, s_reg.tm.sc};
  for (genvar a = 0; a < 2; a++) begin : g_alarm
    logic [`MRTC_AL_FIELDS-1:0] en;
    logic [`MRTC_AL_FIELDS-1:0] hit;
    for (genvar f = 0; f < `MRTC_AL_FIELDS; f++) begin : g_field
      assign en[f] = s_reg.al[a][f][`MRTC_B_EN];
      assign hit[f] = ~en[f] |
        (s_reg.al[a][f][`MRTC_B_EN-1:0] == tv[f][`MRTC_B_EN-1:0]);
    end
    // An alarm with no field enabled never matches.
    assign match[a] = (|en) & (&hit);
  end
  // One event per entry into a matching time; a match lasts at least a whole second.
  assign ev = match & ~s_reg.match_prev;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  logic rise;
  logic tenth;
  logic day;
  logic [2:0] divmax;
  logic [7:0] hlow;
  logic [7:0] rd;
  always_comb begin
    s_next = s_reg;
    rd = 8'h00;
    hlow = 8'h00;
    tenth = 1'b0;
    day = 1'b0;
    // Mains edge detection reads only the second synchroniser stage.
    s_next.sync1 = i_mains;
    s_next.sync2 = s_reg.sync1;
    s_next.prev = s_reg.sync2;
    rise = s_reg.sync2 & ~s_reg.prev;
    divmax = s_reg.ac60 ? `MRTC_DIV60 : `MRTC_DIV50;
    if (s_reg.run && rise) begin
      if (s_reg.div == divmax - 3'h1) begin
        s_next.div = 3'h0;
        tenth = 1'b1;
      end else begin
        s_next.div = s_reg.div + 3'h1;
      end
    end
    // Carry chain, all fields in BCD.
    if (tenth) begin
      s_next.tm.ss = bcd_inc(s_reg.tm.ss);
      if (s_reg.tm.ss == `MRTC_MAX_SS) begin
        s_next.tm.ss = 8'h00;
        s_next.tm.sc = bcd_inc(s_reg.tm.sc);
        if (s_reg.tm.sc == `MRTC_MAX_SEC) begin
          s_next.tm.sc = 8'h00;
          s_next.tm.mn = bcd_inc(s_reg.tm.mn);
          if (s_reg.tm.mn == `MRTC_MAX_SEC) begin
            s_next.tm.mn = 8'h00;
            if (s_reg.tm.hr[`MRTC_B_MIL]) begin
              s_next.tm.hr = bcd_inc(s_reg.tm.hr);
              s_next.tm.hr[`MRTC_B_MIL] = 1'b1;
              if (s_reg.tm.hr[5:0] == `MRTC_MAX_HR24) begin
                s_next.tm.hr[5:0] = 6'h00;
                day = 1'b1;
              end
            end else begin
              hlow = bcd_inc({3'h0, s_reg.tm.hr[4:0]});
              s_next.tm.hr[4:0] = hlow[4:0];
              if (s_reg.tm.hr[4:0] == `MRTC_HR12_TOP) begin
                s_next.tm.hr[4:0] = 5'h01;
              end else if (s_reg.tm.hr[4:0] == `MRTC_HR12_LAST) begin
                s_next.tm.hr[`MRTC_B_PM] = ~s_reg.tm.hr[`MRTC_B_PM];
                day = s_reg.tm.hr[`MRTC_B_PM];
              end
            end
            // Day carry: set only when the hour wraps into a new day.
            if (day) begin
              s_next.tm.dw = (s_reg.tm.dw == `MRTC_MAX_DW) ? 8'h00 : bcd_inc(s_reg.tm.dw);
              s_next.tm.dt = bcd_inc(s_reg.tm.dt);
              if (s_reg.tm.dt == days_in(s_reg.tm.mo, is_leap(s_reg.tm.yr))) begin
                s_next.tm.dt = `MRTC_RST_ONE;
                s_next.tm.mo = bcd_inc(s_reg.tm.mo);
                if (s_reg.tm.mo == `MRTC_MAX_MO) begin
                  s_next.tm.mo = `MRTC_RST_ONE;
                  s_next.tm.yr = bcd_inc(s_reg.tm.yr);
                  if (s_reg.tm.yr == `MRTC_MAX_YR) begin
                    s_next.tm.yr = 8'h00;
                  end
                end
              end
            end
          end
        end
      end
    end
    // Bus access: read data is latched on the first cycle of a request.
    s_next.ack = req & ~s_reg.ack;
    if (req && !s_reg.ack) begin
      unique case (i_avs.address)
        `MRTC_A_SC: rd = s_reg.tm.sc;
        `MRTC_A_MN: rd = s_reg.tm.mn;
        `MRTC_A_HR: rd = s_reg.tm.hr;
        `MRTC_A_DT: rd = s_reg.tm.dt;
        `MRTC_A_MO: rd = s_reg.tm.mo;
        `MRTC_A_YR: rd = s_reg.tm.yr;
        `MRTC_A_DW: rd = s_reg.tm.dw;
        `MRTC_A_SS: rd = s_reg.tm.ss;
        `MRTC_A_STAT: begin
          rd[`MRTC_B_PLF] = s_reg.plf;
          rd[`MRTC_B_ALMA +: 2] = s_reg.flag;
        end
        `MRTC_A_INT: begin
          rd[`MRTC_B_ACLR] = s_reg.aclr;
          rd[`MRTC_B_WEN] = s_reg.wen;
          rd[`MRTC_B_PMODE] = s_reg.pmode;
          rd[`MRTC_B_ALEA +: 2] = s_reg.ale;
        end
        `MRTC_A_AC: rd[`MRTC_B_AC60] = s_reg.ac60;
        default: begin
          for (int k = 0; k < 2; k++) begin
            for (int f = 0; f < `MRTC_AL_FIELDS; f++) begin
              if (i_avs.address == 6'(`MRTC_A_AL0 + k * `MRTC_AL_FIELDS + f)) begin
                rd = s_reg.al[k][f];
              end
            end
          end
        end
      endcase
      s_next.rdata = {24'h000000, rd};
    end
    // Writes take effect on the edge where waitrequest is low.
    if (wr_time) begin
      unique case (i_avs.address)
        `MRTC_A_SC: s_next.tm.sc = wd;
        `MRTC_A_MN: s_next.tm.mn = wd;
        `MRTC_A_HR: s_next.tm.hr = wd;
        `MRTC_A_DT: s_next.tm.dt = wd;
        `MRTC_A_MO: s_next.tm.mo = wd;
        `MRTC_A_YR: s_next.tm.yr = wd;
        `MRTC_A_DW: s_next.tm.dw = wd;
        default: ;
      endcase
      s_next.tm.ss = 8'h00;
      s_next.div = 3'h0;
      s_next.run = 1'b1;
    end
    if (wr && i_avs.address == `MRTC_A_STAT) begin
      if (!wd[`MRTC_B_PLF]) begin
        s_next.plf = 1'b0;
      end
      s_next.flag = s_reg.flag & wd[`MRTC_B_ALMA +: 2];
    end
    if (rd_stat && s_reg.aclr) begin
      s_next.flag = 2'b00;
    end
    if (wr && i_avs.address == `MRTC_A_INT) begin
      s_next.aclr = wd[`MRTC_B_ACLR];
      s_next.wen = wd[`MRTC_B_WEN];
      s_next.pmode = wd[`MRTC_B_PMODE];
      s_next.ale = wd[`MRTC_B_ALEA +: 2];
    end
    if (wr && i_avs.address == `MRTC_A_AC) begin
      s_next.ac60 = wd[`MRTC_B_AC60];
    end
    for (int k = 0; k < 2; k++) begin
      for (int f = 0; f < `MRTC_AL_FIELDS; f++) begin
        if (wr && i_avs.address == 6'(`MRTC_A_AL0 + k * `MRTC_AL_FIELDS + f)) begin
          s_next.al[k][f] = wd;
        end
      end
    end
    // Alarm events set flags after any clear, so a match is never lost.
    s_next.match_prev = match;
    s_next.flag = s_next.flag | ev;
    if (s_reg.pmode && |(ev & s_reg.ale)) begin
      s_next.pcnt = PULSE_CYCLES;
    end else if (s_reg.pcnt != '0) begin
      s_next.pcnt = s_reg.pcnt - `MRTC_PCNT_W'(1);
    end
    if (s_next.pmode) begin
      s_next.irq_oe = s_next.pcnt != '0;
    end else begin
      s_next.irq_oe = |(s_next.flag & s_next.ale);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      s_reg <= '0;
      s_reg.plf <= 1'b1;
      s_reg.ale[0] <= 1'b1;
      s_reg.tm.dt <= `MRTC_RST_ONE;
      s_reg.tm.mo <= `MRTC_RST_ONE;
      for (int k = 0; k < 2; k++) begin
        s_reg.al[k][3] <= `MRTC_RST_ONE;
        s_reg.al[k][4] <= `MRTC_RST_ONE;
      end
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  property p_div_wrap;
    s_reg.run && rise && !wr_time && s_reg.div == divmax - 3'h1 |=> s_reg.div == 3'h0;
  endproperty
  a_div_wrap: assert property (p_div_wrap) else $error("divider did not wrap");

  property p_ss_cause;
    $changed(s_reg.tm.ss) |-> $past(s_reg.run && rise && s_reg.div == divmax - 3'h1) ||
      $past(wr_time);
  endproperty
  a_ss_cause: assert property (p_ss_cause) else $error("tenths moved without cause");

  property p_halt;
    !s_reg.run && !wr_time |=> $stable(s_reg.tm);
  endproperty
  a_halt: assert property (p_halt) else $error("time moved while halted");

  property p_plf_hold;
    s_reg.plf && !(wr && i_avs.address == `MRTC_A_STAT && !wd[`MRTC_B_PLF]) |=> s_reg.plf;
  endproperty
  a_plf_hold: assert property (p_plf_hold) else $error("power-loss flag lost");

  property p_flag_set;
    ev[0] |=> s_reg.flag[0] ##1 (s_reg.flag[0] || $past(wr || rd_stat));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("alarm flag not set");

  property p_wen_block;
    wr && !s_reg.wen && i_avs.address == `MRTC_A_MN |=> $stable(s_reg.tm.mn) || $past(tenth);
  endproperty
  a_wen_block: assert property (p_wen_block) else $error("time write not blocked");

  property p_ss_clear;
    wr_time |=> s_reg.tm.ss == 8'h00 && s_reg.div == 3'h0;
  endproperty
  a_ss_clear: assert property (p_ss_clear) else $error("tenths not cleared");

  property p_single_irq;
    !s_reg.pmode |-> s_reg.irq_oe == |(s_reg.flag & s_reg.ale);
  endproperty
  a_single_irq: assert property (p_single_irq) else $error("single irq level wrong");

  property p_pulse;
    s_reg.pmode && |(ev & s_reg.ale) && !(wr && i_avs.address == `MRTC_A_INT)
      |=> s_reg.pcnt == PULSE_CYCLES ##0 s_reg.irq_oe [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse not started");

  property p_aclr;
    rd_stat && s_reg.aclr && ev == 2'b00 |=> s_reg.flag == 2'b00;
  endproperty
  a_aclr: assert property (p_aclr) else $error("status read did not clear");

  property p_wait_one;
    req && !s_reg.ack |=> !o_avs.waitrequest || !req;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer late");

  property p_div_hold;
    !rise && !wr_time |=> $stable(s_reg.div);
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("divider moved without mains edge");

  property p_run_stays;
    s_reg.run |=> s_reg.run;
  endproperty
  a_run_stays: assert property (p_run_stays) else $error("counter stopped after start");

  property p_flag_clear;
    wr && i_avs.address == `MRTC_A_STAT && !wd[`MRTC_B_ALMA] && !ev[0] |=> !s_reg.flag[0];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("alarm flag not cleared");

  property p_flag_set_b;
    ev[1] |=> s_reg.flag[1];
  endproperty
  a_flag_set_b: assert property (p_flag_set_b) else $error("second alarm flag not set");

  property p_pulse_end;
    s_reg.pmode && s_reg.pcnt == `MRTC_PCNT_W'(1) && !(|(ev & s_reg.ale)) &&
      !(wr && i_avs.address == `MRTC_A_INT) |=> !s_reg.irq_oe;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse did not end");

  c_tenth: cover property (s_reg.run && tenth);
  c_day: cover property (tenth && day);
  c_alarm: cover property (ev[0] && !s_reg.pmode);
  c_pulse: cover property (s_reg.pmode && |(ev & s_reg.ale));
  c_aclr: cover property (rd_stat && s_reg.aclr && s_reg.flag != 2'b00);

endmodule // mrtc_top

/* dv/mrtc_mains_model.sv */
/*
  Mains source seen by the clock block: a squared-up wave sent in bursts.
  Assumes the caller asks for whole periods; between bursts the line rests low.
*/
module mrtc_mains_model (
  // Mains wave out
  output logic o_mains
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HALF_NS = 200;

  initial o_mains = 1'b0;

  // ----------------------------------------
  // Burst generator
  // ----------------------------------------
  // Each burst starts off the system clock grid; the sampling phase stays the same in every burst.
  task automatic send(input int n);
    #7;
    repeat (n) begin
      o_mains = 1'b1;
      #(HALF_NS);
      o_mains = 1'b0;
      #(HALF_NS);
    end
  endtask
endmodule // mrtc_mains_model

/* dv/test_mains_timed_rtc_with_alarms.sv */
/*
  Self-checking bench for the mains-timed clock block: register access,
  calendar carries, alarm flags and interrupt timing.
  Assumes the design package, the design and the mains source model are compiled first.
*/
`include "mrtc_params.svh"
module test_mains_timed_rtc_with_alarms;
  timeunit 1ns;
  timeprecision 1ps;
  import mrtc_pkg::*;

  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam int PW = 20;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  mrtc_avs_req_s req = '0;
  mrtc_avs_rsp_s rsp;
  logic mains;
  logic irq_out;
  logic irq_oe;
  int fails = 0;
  int comparisons = 0;
  // Rows: written sc,mn,hr,dt,mo,yr,dw and the values one second later.
  logic [55:0] tw [4] = '{56'h5959a328020106, 56'h5959a328020406,
                          56'h5959a330040506, 56'h59593131129906};
  logic [55:0] te [4] = '{56'h00008001030100, 56'h00008029020400,
                          56'h00008001050500, 56'h00001201010000};

  always #25 i_clk = ~i_clk;

  mrtc_top #(.PULSE_CYCLES(`MRTC_PCNT_W'(PW))) u_mrtc_top (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_avs(req),
    .o_avs(rsp),
    .i_mains(mains),
    .o_irq_out(irq_out),
    .o_irq_oe(irq_oe)
  );

  mrtc_mains_model u_mrtc_mains_model (
    .o_mains(mains)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waitrequest is read in the edge's own time step, before the design's
  // registers move, so the level seen is the one that this edge samples.
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge i_clk);
    req.address <= a;
    req.read <= ~w;
    req.write <= w;
    req.writedata <= {24'h000000, d};
    req.byteenable <= 4'hf;
    do begin
      @(posedge i_clk);
    end while (rsp.waitrequest !== 1'b0);
    q = rsp.readdata[7:0];
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask

  task automatic tick(input int n);
    u_mrtc_mains_model.send(n);
    repeat (12) @(posedge i_clk);
  endtask

  task automatic pulse_width(output int w);
    int n;
    w = 0;
    n = 0;
    fork
      u_mrtc_mains_model.send(50);
      begin
        while (irq_oe !== 1'b1 && n < 3000) begin
          @(negedge i_clk);
          n++;
        end
        while (irq_oe === 1'b1 && w < 1000) begin
          @(negedge i_clk);
          w++;
        end
      end
    join
    repeat (12) @(posedge i_clk);
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    int w;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(`MRTC_A_STAT, 8'h01);
    rd(`MRTC_A_INT, 8'h01);
    rd(`MRTC_A_AC, 8'h00);
    rd(`MRTC_A_AL0 + 6'h03, 8'h01);
    wr(6'h09, 8'hff);
    rd(6'h09, 8'h00);
    tick(50);
    rd(`MRTC_A_SS, 8'h00);
    wr(`MRTC_A_SC, 8'h05);
    tick(5);
    rd(`MRTC_A_SC, 8'h00);
    wr(`MRTC_A_MN, 8'h07);
    rd(`MRTC_A_MN, 8'h00);
    rd(`MRTC_A_SS, 8'h00);
    wr(`MRTC_A_INT, 8'h40);
    for (int i = 0; i < 2; i++) begin
      wr(`MRTC_A_AC, i ? 8'h80 : 8'h00);
      wr(`MRTC_A_SC, 8'h00);
      tick(4 + i);
      rd(`MRTC_A_SS, 8'h00);
      tick(1);
      rd(`MRTC_A_SS, 8'h01);
      tick(3);
      wr(`MRTC_A_MN, 8'h00);
      rd(`MRTC_A_SS, 8'h00);
    end
    wr(`MRTC_A_AC, 8'h00);
    for (int k = 0; k < 4; k++) begin
      for (int a = 0; a < 7; a++) wr(6'(a), tw[k][8*(6-a) +: 8]);
      tick(50);
      for (int a = 0; a < 7; a++) rd(6'(a), te[k][8*(6-a) +: 8]);
    end
    // Alarm A and B on second 01; the minute byte is loaded but left disabled.
    wr(`MRTC_A_AL0, 8'h81);
    wr(`MRTC_A_AL0 + 6'h01, 8'h05);
    wr(`MRTC_A_AL0 + 6'h06, 8'h81);
    wr(`MRTC_A_INT, 8'h41);
    wr(`MRTC_A_SC, 8'h00);
    tick(50);
    chk({7'h00, irq_oe}, 8'h01);
    chk({7'h00, irq_out}, 8'h00);
    rd(`MRTC_A_STAT, 8'h31);
    tick(50);
    chk({7'h00, irq_oe}, 8'h01);
    wr(`MRTC_A_STAT, 8'h20);
    rd(`MRTC_A_STAT, 8'h20);
    chk({7'h00, irq_oe}, 8'h00);
    wr(`MRTC_A_INT, 8'hc1);
    wr(`MRTC_A_SC, 8'h00);
    tick(50);
    chk({7'h00, irq_oe}, 8'h01);
    rd(`MRTC_A_STAT, 8'h30);
    rd(`MRTC_A_STAT, 8'h00);
    chk({7'h00, irq_oe}, 8'h00);
    wr(`MRTC_A_INT, 8'h61);
    wr(`MRTC_A_SC, 8'h00);
    pulse_width(w);
    chk(w[7:0], 8'(PW));
    rd(`MRTC_A_STAT, 8'h30);
    // The flags stay set: the second pulse must come without re-arming.
    wr(`MRTC_A_SC, 8'h00);
    pulse_width(w);
    chk(w[7:0], 8'(PW));
    stop_test;
  end

  initial begin
    #1000000;
    fails++;
    stop_test;
  end
endmodule // test_mains_timed_rtc_with_alarms
